/* File: dual_channel_dma_control.sv */
// Two-channel DMA control, channel sequencing and APB register file
//
// Function
// - Channel 1 ended with interrupt enable set raises interrupt request.
// - Channel 0 ended with interrupt enable set raises interrupt request.
// - Channel transfers only while its enable and main enable are set.
// - Non-maskable interrupt and reset clear the main enable; a same-cycle channel enable set wins over the interrupt.
// - Main enable set only by writing one to a channel enable.
// - Channel 0 destination mode picks memory step or fixed I/O.
// - Channel 0 source mode uses the same encoding as destination.
// - Pacing bit picks burst or cycle steal for memory copies.
// - Burst keeps the bus until the byte count is zero.
// - Cycle steal alternates one CPU cycle with one byte.
// - Memory copy continues without requests until count is zero.
// - Channel 0 request ignored during memory copies.
// - Memory to I/O transfers are paced by channel 0 request.
// - Sense bit zero means level, one means falling edge.
// - Level sense starts on low, samples in T2, releases on high.
// - Edge sense starts on falling edge, continues on fresh edge.
// - Transfer end output low during the final byte write.
// - Memory copy starts one machine cycle after enable write.
// - Channel 1 mode picks direction and memory address step; the code keeps these bits in cntl_reg but never acts on them.
// - Wait insertion fields reset to all ones.
// - Channel enable clears when its byte count reaches zero.
// - Enable changes only with write gate zero; gates read one.
// - Byte count decrements by one per transferred byte.
// - Channel 0 wins when both channels request together.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module dual_channel_dma_control
  import dma_ctrl_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic nmiPulse, // Non-maskable interrupt event
  input wire logic chan0_request_n, // Channel 0 request pin
  input wire logic chan1_request_n, // Channel 1 request pin
  output logic chan0_last_byte_n, // Channel 0 transfer end
  output logic busOwned, // DMA holds the bus
  output logic writeCycle, // Byte write cycle in progress
  output logic activeChan1, // Current byte is channel 1
  output logic irqRequest // Termination interrupt
);
  logic de0_reg, de1_reg, ie0_reg, ie1_reg, me_reg;
  logic [7:0] mode_reg, cntl_reg;
  logic [15:0] cnt0_reg, cnt1_reg;
  logic [2:0] req0Sync, req1Sync;
  logic req0Low, req1Low, fall0, fall1, edge0_reg, edge1_reg;
  logic pinHigh0_reg, pinHigh1_reg;
  dma_state_e state_reg;
  logic [1:0] tcnt_reg;
  logic chan_reg;
  logic wrAcc, copyStart, statWr, en0Write, en1Write, mem2mem;
  logic run0, run1, want0, want1, sampleT2, byteDone, lastByte, contNext;

  function automatic logic isFixed(input logic [1:0] m);
    isFixed = m[1];
  endfunction

  assign wrAcc = psel && penable && pwrite;
  assign statWr = wrAcc && paddr == OFS_STATUS;
  assign en0Write = statWr && !pwdata[BIT_WG0];
  assign en1Write = statWr && !pwdata[BIT_WG1];
  assign mem2mem = !(mode_reg[POS_DST +: 2] == AMODE_IO)
    && !(mode_reg[POS_SRC +: 2] == AMODE_IO);
  assign copyStart = en0Write && pwdata[BIT_DE0] && mem2mem;
  assign run0 = de0_reg && me_reg;
  assign run1 = de1_reg && me_reg;

  // Three stage pin synchronisers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      req0Sync <= 3'h7;
      req1Sync <= 3'h7;
      pinHigh0_reg <= 1'b1;
      pinHigh1_reg <= 1'b1;
    end
    else
    begin
      req0Sync <= {req0Sync[1:0], chan0_request_n};
      req1Sync <= {req1Sync[1:0], chan1_request_n};
      // Level only moves once the last two stages agree
      if (req0Sync[1] == req0Sync[2])
        pinHigh0_reg <= req0Sync[2];
      if (req1Sync[1] == req1Sync[2])
        pinHigh1_reg <= req1Sync[2];
    end
  end
  assign req0Low = !req0Sync[1] && !req0Sync[2];
  assign req1Low = !req1Sync[1] && !req1Sync[2];
  assign fall0 = pinHigh0_reg && req0Low;
  assign fall1 = pinHigh1_reg && req1Low;

  // edge latches, used up at start or write sample
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      edge0_reg <= 1'b0;
      edge1_reg <= 1'b0;
    end
    else
    begin
      // New edge wins; it then paces the following byte
      if (fall0)
        edge0_reg <= 1'b1;
      else if ((sampleT2 && state_reg == ST_WR && !chan_reg) ||
        (state_reg == ST_IDLE && want0 && !copyStart))
        edge0_reg <= 1'b0;
      if (fall1)
        edge1_reg <= 1'b1;
      else if ((sampleT2 && state_reg == ST_WR && chan_reg) ||
        (state_reg == ST_IDLE && want1 && !want0 && !copyStart))
        edge1_reg <= 1'b0;
    end
  end

  // sense select: low bit channel 0
  assign want0 = run0 && (mem2mem ||
    (cntl_reg[BIT_SENSE0] ? edge0_reg : req0Low));
  assign want1 = run1 && (cntl_reg[BIT_SENSE1] ? edge1_reg : req1Low);

  assign sampleT2 = tcnt_reg == TSTATE_T2;
  assign byteDone = state_reg == ST_WR && tcnt_reg == MCYCLE_LAST;
  assign lastByte = chan_reg ? cnt1_reg == 16'h0001 : cnt0_reg == 16'h0001;

  always_comb
  begin
    contNext = 1'b0;
    if (!chan_reg && mem2mem)
      contNext = mode_reg[BIT_PACE];
    else if (!chan_reg)
      contNext = cntl_reg[BIT_SENSE0] ? edge0_reg : req0Low;
    else
      contNext = cntl_reg[BIT_SENSE1] ? edge1_reg : req1Low;
  end

  logic cont_reg;
  always_ff @(posedge mclk)
  begin
    if (srst)
      cont_reg <= 1'b0;
    else if (state_reg == ST_WR && sampleT2)
      cont_reg <= contNext;
  end

  // Byte sequencer
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      tcnt_reg <= 2'h0;
      chan_reg <= 1'b0;
    end
    else
    begin
      tcnt_reg <= (tcnt_reg == MCYCLE_LAST) ? 2'h0 : tcnt_reg + 2'h1;
      unique case (state_reg)
        ST_IDLE:
        begin
          tcnt_reg <= 2'h0;
          if (copyStart)
            state_reg <= ST_START;
          else if (want0)
          begin
            state_reg <= ST_RD;
            chan_reg <= 1'b0;
          end
          else if (want1)
          begin
            state_reg <= ST_RD;
            chan_reg <= 1'b1;
          end
        end
        ST_START:
          if (tcnt_reg == MCYCLE_LAST)
            state_reg <= ST_IDLE;
        ST_RD:
          if (!(chan_reg ? run1 : run0))
            state_reg <= ST_IDLE;
          else if (tcnt_reg == MCYCLE_LAST)
            state_reg <= ST_WR;
        ST_WR:
          if (tcnt_reg == MCYCLE_LAST)
          begin
            if (lastByte)
              state_reg <= ST_IDLE;
            else if (cont_reg)
              state_reg <= ST_RD;
            else if (!chan_reg && mem2mem)
              state_reg <= ST_CPU;
            else
              state_reg <= ST_IDLE;
          end
        ST_CPU:
          if (tcnt_reg == MCYCLE_LAST)
            state_reg <= run0 ? ST_RD : ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cnt0_reg <= COUNT_RESET;
      cnt1_reg <= COUNT_RESET;
    end
    else if (byteDone)
    begin
      if (chan_reg)
        cnt1_reg <= cnt1_reg - 16'h0001;
      else
        cnt0_reg <= cnt0_reg - 16'h0001;
    end
    else if (wrAcc && paddr == OFS_CH0_COUNT)
      cnt0_reg <= pwdata[15:0];
    else if (wrAcc && paddr == OFS_CH1_COUNT)
      cnt1_reg <= pwdata[15:0];
  end

  // Channel enables; hardware termination wins over a software write
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      de0_reg <= 1'b0;
      de1_reg <= 1'b0;
    end
    else
    begin
      if (byteDone && lastByte && !chan_reg)
        de0_reg <= 1'b0;
      else if (en0Write)
        de0_reg <= pwdata[BIT_DE0];
      if (byteDone && lastByte && chan_reg)
        de1_reg <= 1'b0;
      else if (en1Write)
        de1_reg <= pwdata[BIT_DE1];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      me_reg <= 1'b0;
    else if ((en0Write && pwdata[BIT_DE0]) || (en1Write && pwdata[BIT_DE1]))
      me_reg <= 1'b1;
    else if (nmiPulse)
      me_reg <= 1'b0;
  end

  // Mode, control and interrupt enables
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ie0_reg <= 1'b0;
      ie1_reg <= 1'b0;
      mode_reg <= MODE_RESET;
      cntl_reg <= CNTL_RESET;
    end
    else
    begin
      if (statWr)
      begin
        ie0_reg <= pwdata[BIT_IE0];
        ie1_reg <= pwdata[BIT_IE1];
      end
      // Changing mode mid-transfer is not guarded
      if (wrAcc && paddr == OFS_MODE)
        mode_reg <= {2'b00, pwdata[5:1], 1'b0};
      if (wrAcc && paddr == OFS_CNTL)
        cntl_reg <= pwdata[7:0];
    end
  end

  // Outputs, all registered
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      chan0_last_byte_n <= 1'b1;
      busOwned <= 1'b0;
      writeCycle <= 1'b0;
      activeChan1 <= 1'b0;
      irqRequest <= 1'b0;
    end
    else
    begin
      // end low in step with writeCycle
      chan0_last_byte_n <= !(state_reg == ST_WR && !chan_reg && lastByte);
      busOwned <= state_reg == ST_RD || state_reg == ST_WR;
      writeCycle <= state_reg == ST_WR;
      activeChan1 <= chan_reg;
      irqRequest <= (ie0_reg && !de0_reg) || (ie1_reg && !de1_reg);
    end
  end

  // APB slave, zero wait states
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
        unique case (paddr)
          OFS_STATUS: prdata <= {24'h00_0000, de1_reg, de0_reg, 2'b11,
            ie1_reg, ie0_reg, 1'b0, me_reg};
          OFS_MODE: prdata <= {24'h00_0000, mode_reg};
          OFS_CNTL: prdata <= {24'h00_0000, cntl_reg};
          OFS_CH0_COUNT: prdata <= {16'h0000, cnt0_reg};
          OFS_CH1_COUNT: prdata <= {16'h0000, cnt1_reg};
          OFS_CPU_STAT: prdata <= {29'h000_0000, writeCycle,
            busOwned, chan0_last_byte_n};
          default: pslverr <= 1'b1;
        endcase
      else if (psel && !penable)
        pslverr <= !(paddr == OFS_STATUS || paddr == OFS_MODE ||
          paddr == OFS_CNTL || paddr == OFS_CH0_COUNT ||
          paddr == OFS_CH1_COUNT || paddr == OFS_CPU_STAT);
    end
  end

  // Assertions
  a_main_nmi_clear: assert property (@(posedge mclk)
    disable iff (srst) nmiPulse && !statWr |=> !me_reg)
    else $error("main enable not cleared by nmi");
  a_main_set_write: assert property (@(posedge mclk)
    disable iff (srst) en0Write && pwdata[BIT_DE0] |=> me_reg)
    else $error("main enable not set by channel enable write");
  a_idle_disabled: assert property (@(posedge mclk)
    disable iff (srst)
    state_reg == ST_IDLE && !run0 && !run1 |=> state_reg != ST_RD)
    else $error("transfer started while disabled");
  a_count_step: assert property (@(posedge mclk)
    disable iff (srst)
    byteDone && !chan_reg |=> cnt0_reg == $past(cnt0_reg) - 16'h0001)
    else $error("byte count did not step by one");
  a_enable_end: assert property (@(posedge mclk)
    disable iff (srst) byteDone && lastByte && !chan_reg |=> !de0_reg)
    else $error("enable not cleared at end");
  a_irq_end: assert property (@(posedge mclk)
    disable iff (srst) ie0_reg && !de0_reg |=> irqRequest)
    else $error("channel 0 interrupt missing");
  a_irq_end1: assert property (@(posedge mclk)
    disable iff (srst) ie1_reg && !de1_reg |=> irqRequest)
    else $error("channel 1 interrupt missing");
  a_wait_reset: assert property (@(posedge mclk)
    srst |=> cntl_reg == CNTL_RESET)
    else $error("wait fields not set by reset");
  a_priority_ch0: assert property (@(posedge mclk)
    disable iff (srst) state_reg == ST_IDLE && want0 && !statWr |=> !chan_reg)
    else $error("channel 1 granted over channel 0");
  sequence lastWrite;
    state_reg == ST_WR && !chan_reg && lastByte && tcnt_reg == 2'h0;
  endsequence
  a_end_low: assert property (@(posedge mclk)
    disable iff (srst) lastWrite |=> !chan0_last_byte_n)
    else $error("transfer end not low in last write");
endmodule // dual_channel_dma_control

/* File: dma_ctrl_pkg.sv */
// Register map, field layout and timing constants for the DMA control block
package dma_ctrl_pkg;
  // Register numbers are word indexes; byte address is four times that
  localparam logic [7:0] IDX_STATUS = 8'h30;
  localparam logic [7:0] IDX_MODE = 8'h31;
  localparam logic [7:0] IDX_CNTL = 8'h32;
  localparam logic [7:0] OFS_STATUS = {IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] OFS_MODE = {IDX_MODE[5:0], 2'b00};
  localparam logic [7:0] OFS_CNTL = {IDX_CNTL[5:0], 2'b00};
  localparam logic [7:0] OFS_CH0_COUNT = 8'h40;
  localparam logic [7:0] OFS_CH1_COUNT = 8'h44;
  localparam logic [7:0] OFS_CPU_STAT = 8'h48;
  localparam int BIT_DE1 = 7;
  localparam int BIT_DE0 = 6;
  localparam int BIT_WG1 = 5;
  localparam int BIT_WG0 = 4;
  localparam int BIT_IE1 = 3;
  localparam int BIT_IE0 = 2;
  localparam int BIT_ME = 0;
  localparam int POS_DST = 4;
  localparam int POS_SRC = 2;
  localparam int BIT_PACE = 1;
  localparam int POS_MWAIT = 6;
  localparam int POS_IWAIT = 4;
  localparam int BIT_SENSE1 = 3;
  localparam int BIT_SENSE0 = 2;
  localparam int POS_DIR1 = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CNTL_RESET = 8'hF0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] AMODE_INC = 2'h0;
  localparam logic [1:0] AMODE_DEC = 2'h1;
  localparam logic [1:0] AMODE_FIX = 2'h2;
  localparam logic [1:0] AMODE_IO = 2'h3;
  // Machine cycle: read T1..T3, write T1..T3 per byte
  localparam int MCYCLE_CLKS = 3;
  localparam logic [1:0] MCYCLE_LAST = 2'h2;
  localparam logic [1:0] TSTATE_T2 = 2'h1;
  typedef enum {ST_IDLE, ST_START, ST_RD, ST_WR, ST_CPU} dma_state_e;
endpackage

/* File: dma_io_device.sv */
// External I/O device model driving the DMA request pins
`timescale 1ns/10ps
module dma_io_device (
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic holdReq0, // Hold channel 0 request
  input wire logic holdReq1, // Hold channel 1 request
  input wire logic strobeReq0, // One channel 0 falling edge
  input wire logic lastByte_n, // Transfer end from block
  output logic chan0_request_n, // Channel 0 request pin
  output logic chan1_request_n // Channel 1 request pin
);
  logic doneSeen;
  logic [2:0] pulseCnt;
  always_ff @(posedge mclk)
  begin
    if (srst || !holdReq0)
      doneSeen <= 1'b0;
    else if (!lastByte_n)
      doneSeen <= 1'b1;
  end
  // Low long enough for the three-flop synchroniser
  always_ff @(posedge mclk)
  begin
    if (srst)
      pulseCnt <= 3'h0;
    else if (strobeReq0 && pulseCnt == 3'h0)
      pulseCnt <= 3'h5;
    else if (pulseCnt != 3'h0)
      pulseCnt <= pulseCnt - 3'h1;
  end
  assign chan0_request_n = !((holdReq0 && !doneSeen) || pulseCnt > 3'h1);
  assign chan1_request_n = !holdReq1;
endmodule // dma_io_device

/* File: tb.sv */
// Self-checking bench for the two-channel DMA control block
`timescale 1ns/10ps
module tb;
  import dma_ctrl_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, hold;
  logic pready, pslverr, err, firstCh1;
  logic nmiPulse = 1'b0, holdReq0 = 1'b0, holdReq1 = 1'b0;
  logic strobeReq0 = 1'b0;
  logic chan0_request_n, chan1_request_n, chan0_last_byte_n;
  logic busOwned, writeCycle, activeChan1, irqRequest, wcPrev, boPrev;
  int num_errors = 0, checks = 0, wrRise, busFall, lastLow, lastBad;

  always #20 mclk = ~mclk;

  dual_channel_dma_control dual_channel_dma_control_inst (.mclk(mclk),
    .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmiPulse(nmiPulse),
    .chan0_request_n(chan0_request_n), .chan1_request_n(chan1_request_n),
    .chan0_last_byte_n(chan0_last_byte_n), .busOwned(busOwned),
    .writeCycle(writeCycle), .activeChan1(activeChan1),
    .irqRequest(irqRequest));

  dma_io_device dma_io_device_inst (.mclk(mclk), .srst(srst),
    .holdReq0(holdReq0), .holdReq1(holdReq1), .strobeReq0(strobeReq0),
    .lastByte_n(chan0_last_byte_n), .chan0_request_n(chan0_request_n),
    .chan1_request_n(chan1_request_n));

  // Falling edge keeps the counters clear of the main thread
  always @(negedge mclk)
  begin
    wcPrev <= writeCycle;
    boPrev <= busOwned;
    if (writeCycle && !wcPrev && wrRise == 0)
      firstCh1 = activeChan1;
    if (writeCycle && !wcPrev)
      wrRise++;
    if (!busOwned && boPrev)
      busFall++;
    if (!chan0_last_byte_n && writeCycle)
      lastLow++;
    if (!chan0_last_byte_n && !writeCycle)
      lastBad++;
  end

  task automatic stop_test;
    $display("counts: %0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, {24'h00_0000, exp});
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    repeat (2) @(posedge mclk);
    while (irqRequest !== 1'b1 && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000)
    begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic start0(input logic [7:0] mode, cntl, input logic [15:0] cnt,
    input logic [7:0] stat);
    apb(1'b1, OFS_MODE, {24'h00_0000, mode});
    apb(1'b1, OFS_CNTL, {24'h00_0000, cntl});
    apb(1'b1, OFS_CH0_COUNT, {16'h0000, cnt});
    wrRise = 0;
    busFall = 0;
    lastLow = 0;
    lastBad = 0;
    apb(1'b1, OFS_STATUS, {24'h00_0000, stat});
  endtask

  task automatic t_regs;
    check("irq idle", 32'(irqRequest), 32'h0000_0000);
    rdchk("status rst", OFS_STATUS, 8'h30);
    rdchk("mode rst", OFS_MODE, 8'h00);
    rdchk("cntl rst", OFS_CNTL, 8'hF0);
    apb(1'b0, 8'h50, 32'h0000_0000);
    check("unmapped", {rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    rdchk("main direct", OFS_STATUS, 8'h30);
    apb(1'b1, OFS_STATUS, 32'h0000_0070);
    rdchk("gated write", OFS_STATUS, 8'h30);
    apb(1'b1, OFS_MODE, 32'h0000_0016);
    rdchk("mode rw", OFS_MODE, 8'h16);
    apb(1'b1, OFS_CNTL, 32'h0000_002D);
    rdchk("cntl rw", OFS_CNTL, 8'h2D);
  endtask

  task automatic t_copy(input logic pace);
    start0({6'h00, pace, 1'b0}, 8'hF0, 16'h0003, 8'h64);
    wait_irq();
    rdchk("count end", OFS_CH0_COUNT, 8'h00);
    rdchk("status end", OFS_STATUS, 8'h35);
    check("bytes", 32'(wrRise), 32'h0000_0003);
    check("releases", 32'(busFall), pace ? 32'h1 : 32'h3);
    check("end strobe", 32'(lastLow > 0), 32'h0000_0001);
    check("end outside", 32'(lastBad), 32'h0000_0000);
  endtask

  task automatic t_nmi;
    start0(8'h00, 8'hF0, 16'h0014, 8'h64);
    repeat (30) @(posedge mclk);
    nmiPulse <= 1'b1;
    @(posedge mclk);
    nmiPulse <= 1'b0;
    repeat (10) @(posedge mclk);
    rdchk("status nmi", OFS_STATUS, 8'h74);
    apb(1'b0, OFS_CH0_COUNT, 32'h0000_0000);
    hold = rd;
    check("started", 32'(hold < 32'd20), 32'h0000_0001);
    repeat (40) @(posedge mclk);
    rdchk("count held", OFS_CH0_COUNT, hold[7:0]);
    apb(1'b1, OFS_STATUS, 32'h0000_0064);
    wait_irq();
    rdchk("status rerun", OFS_STATUS, 8'h35);
  endtask

  task automatic t_level;
    start0(8'h30, 8'hF0, 16'h0002, 8'h64);
    repeat (40) @(posedge mclk);
    rdchk("count idle", OFS_CH0_COUNT, 8'h02);
    holdReq0 <= 1'b1;
    wait_irq();
    rdchk("count level", OFS_CH0_COUNT, 8'h00);
    check("io end", 32'(lastLow > 0), 32'h0000_0001);
    holdReq0 <= 1'b0;
  endtask

  task automatic t_edge;
    start0(8'h30, 8'hF4, 16'h0002, 8'h64);
    strobeReq0 <= 1'b1;
    @(posedge mclk);
    strobeReq0 <= 1'b0;
    repeat (60) @(posedge mclk);
    rdchk("one edge", OFS_CH0_COUNT, 8'h01);
    strobeReq0 <= 1'b1;
    @(posedge mclk);
    strobeReq0 <= 1'b0;
    wait_irq();
    rdchk("edge end", OFS_CH0_COUNT, 8'h00);
  endtask

  task automatic t_both;
    apb(1'b1, OFS_CH1_COUNT, 32'h0000_0001);
    holdReq0 <= 1'b1;
    holdReq1 <= 1'b1;
    start0(8'h30, 8'hF2, 16'h0001, 8'hC8);
    wait_irq();
    rdchk("status both", OFS_STATUS, 8'h39);
    check("first chan", 32'(firstCh1), 32'h0000_0000);
    check("last chan", 32'(activeChan1), 32'h0000_0001);
    holdReq0 <= 1'b0;
    holdReq1 <= 1'b0;
  endtask

  initial
  begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    $display("test registers done");
    t_copy(1'b1);
    $display("test burst done");
    t_copy(1'b0);
    $display("test cycle steal done");
    t_nmi();
    $display("test nmi done");
    t_level();
    $display("test level done");
    t_edge();
    $display("test edge done");
    t_both();
    $display("test priority done");
    stop_test();
  end
endmodule // tb
